// ===== design/trs_pkg.sv
// constants shared by the rail sequencer and its per-rail guard
// assumes a 250 MHz core clock; times are held in microseconds and in clock cycles
package trs_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ    = 250;
	localparam int unsigned SS_MIN_US  = 1500;
	localparam int unsigned GAP_US     = 1000;
	localparam int unsigned SS_DCH_US  = 500;
	localparam int unsigned EN_DCH_US  = 500;
	localparam int unsigned HICCUP_US  = 4000;
	localparam int unsigned SS_MIN_CYC = SS_MIN_US * CLK_MHZ;
	localparam int unsigned GAP_CYC    = GAP_US * CLK_MHZ;
	localparam int unsigned SS_DCH_CYC = SS_DCH_US * CLK_MHZ;
	localparam int unsigned EN_DCH_CYC = EN_DCH_US * CLK_MHZ;
	localparam int unsigned HICCUP_CYC = HICCUP_US * CLK_MHZ;
	localparam int          CNT_W      = 21;

	// ----------------------------------------------------------------
	// over-current blanking
	// ----------------------------------------------------------------
	localparam logic [2:0] STREAK_MAX = 3'h4;
	localparam logic [4:0] BLANK_ONE  = 5'h01;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	localparam logic [3:0]  REG_CTRL     = 4'h0;
	localparam logic [3:0]  REG_STATUS   = 4'h4;
	localparam logic [31:0] CTRL_RESET   = 32'h0;
	localparam int          CTRL_HOLD    = 0;
	localparam int          ST_RAIL_LSB  = 0;
	localparam int          ST_LOCK      = 3;
	localparam int          ST_THERM     = 4;
	localparam int          ST_HIC_LSB   = 5;
	localparam int          ST_BUSY      = 8;

	// ----------------------------------------------------------------
	// synchroniser vector layout
	// ----------------------------------------------------------------
	localparam int IX_EN    = 0;
	localparam int IX_MAIN  = 3;
	localparam int IX_SEC   = 4;
	localparam int IX_HOT   = 5;
	localparam int IX_COOL  = 6;
	localparam int IX_MATCH = 7;
	localparam int IX_DONE  = 8;
	localparam int IX_TICK  = 9;
	localparam int IX_OC    = 10;
	localparam int IX_UV    = 13;
	localparam int SYNC_W   = 16;

	typedef enum logic [2:0] {
		S_PWRUP, S_IDLE, S_PRE, S_RAMP, S_GAP, S_DCH
	} trs_state_t;

endpackage : trs_pkg

// ===== design/trs_guard.sv
// per-rail over-current blanking and hiccup restart
// assumes tick is a one-cycle pulse per switching cycle, inputs synced
`timescale 1ns/100ps
module trs_guard
	import trs_pkg::*;
#(
	parameter int unsigned HIC_CYC = HICCUP_CYC
)(
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic ce,
	input  wire logic rail_on,
	input  wire logic tick,
	input  wire logic oc,
	input  wire logic uv,
	output logic      hs_allow,
	output logic      hiccup
);
	logic [4:0]       blank;
	logic [2:0]       streak;
	logic [CNT_W-1:0] hcnt;
	wire              idle_cyc = blank == 5'h00;
	wire              sample   = ce & tick & idle_cyc & rail_on & ~hiccup;
	wire              trip     = uv & (oc | streak != 3'h0);
	wire              hic_end  = hcnt == CNT_W'(HIC_CYC - 1);

	assign hs_allow = rail_on & ~hiccup & idle_cyc;

	// ----------------------------------------------------------------
	// blanking: 1, 2, 4, 8, then 16 cycles for a running streak
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			blank  <= 5'h00;
			streak <= 3'h0;
		end
		else if (ce & (hiccup | ~rail_on))
		begin
			blank  <= 5'h00;
			streak <= 3'h0;
		end
		else if (ce & tick & ~idle_cyc)
			blank <= blank - 5'h01;
		else if (sample & oc)
		begin
			blank  <= BLANK_ONE << streak;
			streak <= (streak == STREAK_MAX) ? streak : streak + 3'h1;
		end
		else if (sample)
			streak <= 3'h0;
	end

	// ----------------------------------------------------------------
	// hiccup: off for a fixed time, then the sequencer restarts it
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			hiccup <= 1'b0;
			hcnt   <= '0;
		end
		else if (ce & hiccup)
		begin
			hiccup <= ~hic_end;
			hcnt   <= hic_end ? '0 : hcnt + 1'b1;
		end
		else if (ce & rail_on & trip)
			hiccup <= 1'b1;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	first_blank_a: assert property (
		sample & oc & streak == 3'h0 & ~trip |=> blank == 5'h01)
		else $error("first over-current did not blank one cycle");
	max_blank_a: assert property (
		sample & oc & streak == STREAK_MAX & ~trip |=> blank == 5'h10)
		else $error("blanking did not stop at sixteen cycles");
	hic_hold_a: assert property (
		$rose(hiccup) |-> hiccup[*8])
		else $error("hiccup off-time ended too early");
	hic_drive_a: assert property (
		ce & $rose(hiccup) |=> !rail_on)
		else $error("rail kept on after hiccup");
endmodule : trs_guard

// ===== design/trs_seq.sv
// three-rail power-up sequencer with supply and thermal supervision
// assumes comparator results arrive asynchronously; avalon-mm on clk
//
// How it works
// - several tied-high pins start one, two, three
// - next start waits soft-start plus 1 ms
// - grounded pin off; tied-high pin starts immediately
// - rail starts when pin crosses enable threshold
// - power-up discharges pins, then charges them
// - pins rising mid-ramp follow default order
// - blank next cycle after over-current
// - blanking doubles up to sixteen cycles
// - under-voltage in overload shuts rail down
// - hiccup: off fixed time, restart, repeat
// - pre-charge soft-start before charging it
// - ramp complete at 0.8 V
// - discharge soft-start before next rail
// - main supply low disables all rails
// - secondary low with two/three on disables all
// - supply lockout not latched
// - pins held discharged during lockout
// - over-temperature disables rails, discharges pins
// - thermal trip at 160, release 20 lower
`timescale 1ns/100ps
module trs_seq
	import trs_pkg::*;
#(
	parameter int unsigned P_SS_MIN  = SS_MIN_CYC,
	parameter int unsigned P_GAP     = GAP_CYC,
	parameter int unsigned P_SS_DCH  = SS_DCH_CYC,
	parameter int unsigned P_EN_DCH  = EN_DCH_CYC,
	parameter int unsigned P_HICCUP  = HICCUP_CYC
)(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        ce,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [2:0]  rail_enable_input,
	input  wire logic        main_supply_low,
	input  wire logic        secondary_supply_low,
	input  wire logic        thermal_hot,
	input  wire logic        thermal_cooled,
	input  wire logic        ss_match,
	input  wire logic        ss_done,
	input  wire logic        sw_tick,
	input  wire logic [2:0]  oc_detect,
	input  wire logic [2:0]  uv_detect,
	output logic             en_discharge,
	output logic             en_source_on,
	output logic [2:0]       rail_enable,
	output logic [2:0]       hs_allow,
	output logic             ss_precharge,
	output logic             ss_charge,
	output logic             ss_discharge
);
	logic [SYNC_W-1:0] sync1;
	logic [SYNC_W-1:0] sync2;
	logic              tick_d;
	logic [2:0]        rail_on;
	logic [2:0]        hiccup;
	logic              thermal;
	logic              hold_off;
	logic              ack;
	logic [CNT_W-1:0]  cnt;
	logic [CNT_W-1:0]  next_cnt;
	trs_state_t        state;
	trs_state_t        next_state;
	logic [2:0]        next_rail_on;

	// ----------------------------------------------------------------
	// input synchroniser
	// ----------------------------------------------------------------
	wire [SYNC_W-1:0] raw = {uv_detect, oc_detect, sw_tick, ss_done,
		ss_match, thermal_cooled, thermal_hot, secondary_supply_low,
		main_supply_low, rail_enable_input};

	// only the second stage is read anywhere
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sync1  <= '0;
			sync2  <= '0;
			tick_d <= 1'b0;
		end
		else if (ce)
		begin
			sync1  <= raw;
			sync2  <= sync1;
			tick_d <= sync2[IX_TICK];
		end
	end

	wire [2:0] en_s    = sync2[IX_EN +: 3];
	wire       main_lo = sync2[IX_MAIN];
	wire       sec_lo  = sync2[IX_SEC];
	wire       hot_s   = sync2[IX_HOT];
	wire       cool_s  = sync2[IX_COOL];
	wire       match_s = sync2[IX_MATCH];
	wire       done_s  = sync2[IX_DONE];
	wire       tick_p  = sync2[IX_TICK] & ~tick_d;
	wire [2:0] oc_s    = sync2[IX_OC +: 3];
	wire [2:0] uv_s    = sync2[IX_UV +: 3];

	// ----------------------------------------------------------------
	// supervision
	// ----------------------------------------------------------------
	// lockout is a pure level: it clears with its supplies
	wire lockout = main_lo
		| (sec_lo & (rail_on[1] | rail_on[2]));
	wire fault   = lockout | thermal | hold_off;

	// hot sets, cooled clears; set wins when both appear
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			thermal <= 1'b0;
		else if (ce)
			thermal <= hot_s | (thermal & ~cool_s);
	end

	// ----------------------------------------------------------------
	// per-rail over-current guards
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : rail
			trs_guard #(
				.HIC_CYC (P_HICCUP)
			) u_guard (
				.clk      (clk),
				.reset_n  (reset_n),
				.ce       (ce),
				.rail_on  (rail_on[g]),
				.tick     (tick_p),
				.oc       (oc_s[g]),
				.uv       (uv_s[g]),
				.hs_allow (hs_allow[g]),
				.hiccup   (hiccup[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	wire [2:0] pend = en_s & ~rail_on & ~hiccup;
	// lowest index wins, which gives the default order
	wire [2:0] pick = pend & ~{pend[1:0], 1'b0} & ~{pend[0], 2'b0};
	wire       pwr_end = cnt == CNT_W'(P_EN_DCH - 1);
	wire       ss_min  = cnt >= CNT_W'(P_SS_MIN - 1);
	wire       gap_end = cnt == CNT_W'(P_GAP - 1);
	wire       dch_end = cnt == CNT_W'(P_SS_DCH - 1);

	always_comb
	begin
		next_state   = state;
		next_cnt     = cnt + 1'b1;
		// a pin dropping or a hiccup removes its rail at once
		next_rail_on = rail_on & en_s & ~hiccup;
		case (state)
			S_PWRUP:
				if (pwr_end)
				begin
					next_state = S_IDLE;
					next_cnt   = '0;
				end
			S_IDLE:
			begin
				next_cnt = '0;
				if (pend != 3'h0)
				begin
					next_rail_on = next_rail_on | pick;
					next_state   = S_PRE;
				end
			end
			S_PRE:
			begin
				next_cnt = '0;
				if (match_s)
					next_state = S_RAMP;
			end
			S_RAMP:
				if (done_s & ss_min)
				begin
					next_state = S_GAP;
					next_cnt   = '0;
				end
			S_GAP:
				if (gap_end)
				begin
					next_state = S_DCH;
					next_cnt   = '0;
				end
			S_DCH:
				if (dch_end)
				begin
					next_state = S_IDLE;
					next_cnt   = '0;
				end
			default:
			begin
				next_state = S_PWRUP;
				next_cnt   = '0;
			end
		endcase
		if (fault)
		begin
			next_state   = S_PWRUP;
			next_cnt     = '0;
			next_rail_on = 3'h0;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state   <= S_PWRUP;
			cnt     <= '0;
			rail_on <= 3'h0;
		end
		else if (ce)
		begin
			state   <= next_state;
			cnt     <= next_cnt;
			rail_on <= next_rail_on;
		end
	end

	assign en_discharge = state == S_PWRUP;
	assign en_source_on = state != S_PWRUP;
	assign rail_enable  = rail_on;
	assign ss_precharge = state == S_PRE;
	assign ss_charge    = state == S_RAMP || state == S_GAP;
	assign ss_discharge = state == S_DCH || state == S_PWRUP;

	// ----------------------------------------------------------------
	// avalon-mm slave, one wait state on every access
	// ----------------------------------------------------------------
	wire req     = avs_read | avs_write;
	wire sel_ctl = avs_address == REG_CTRL;
	wire sel_st  = avs_address == REG_STATUS;
	wire busy    = state != S_IDLE && state != S_PWRUP;

	wire [31:0] status_word = {23'h0, busy, hiccup, thermal, lockout,
		rail_on};
	wire [31:0] ctrl_word   = {31'h0, hold_off};
	wire [31:0] rd_mux      = sel_ctl ? ctrl_word :
		sel_st ? status_word : 32'h0;

	assign avs_waitrequest = ~ack;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ack          <= 1'b0;
			avs_readdata <= 32'h0;
			hold_off     <= CTRL_RESET[CTRL_HOLD];
		end
		else if (ce)
		begin
			ack <= req & ~ack;
			if (avs_read & ~ack)
				avs_readdata <= rd_mux;
			if (avs_write & ack & sel_ctl)
				hold_off <= avs_writedata[CTRL_HOLD];
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence ramp_to_gap_s;
		state == S_RAMP ##1 state == S_GAP;
	endsequence

	sequence start_two_s;
		ce & state == S_IDLE & ~fault & pend[0] & pend[1];
	endsequence

	sequence dch_to_idle_s;
		state == S_DCH ##1 state == S_IDLE;
	endsequence

	default_order_a: assert property (
		start_two_s |=> rail_on[0] & !rail_on[1])
		else $error("rail two started before rail one");
	ramp_min_a: assert property (
		ramp_to_gap_s |-> $past(cnt) >= CNT_W'(P_SS_MIN - 1))
		else $error("soft-start minimum not honoured");
	start_idle_a: assert property (
		$rose(rail_on[1]) |-> $past(state) == S_IDLE)
		else $error("rail started outside idle");
	lockout_off_a: assert property (
		ce & main_lo |=> rail_on == 3'h0 & en_discharge)
		else $error("rails stayed on under lockout");
	therm_pins_a: assert property (
		ce & thermal |=> en_discharge & rail_on == 3'h0)
		else $error("pins not discharged in thermal trip");
	therm_set_a: assert property (
		ce & hot_s |=> thermal)
		else $error("thermal trip not taken");
	precharge_a: assert property (
		$rose(ss_charge) |-> $past(ss_precharge))
		else $error("soft-start charged without pre-charge");
	bus_answer_a: assert property (
		ce & req & avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	ramp_done_a: assert property (
		ramp_to_gap_s |-> $past(done_s))
		else $error("ramp left before soft-start done");
	dch_len_a: assert property (
		dch_to_idle_s |-> $past(cnt) == CNT_W'(P_SS_DCH - 1))
		else $error("soft-start discharge cut short");
	pins_rel_a: assert property (
		$fell(en_discharge) |-> $past(cnt) == CNT_W'(P_EN_DCH - 1))
		else $error("pin discharge cut short");
	one_start_a: assert property (
		ce & state == S_IDLE |=>
			$countones(rail_on & ~$past(rail_on)) <= 1)
		else $error("two rails started together");
	no_late_a: assert property (
		ce & state != S_IDLE |=> (rail_on & ~$past(rail_on)) == 3'h0)
		else $error("rail started while another ramps");
	sec_lock_a: assert property (
		ce & sec_lo & (rail_on[1] | rail_on[2]) |=> rail_on == 3'h0)
		else $error("secondary lockout left rails on");
	hold_off_a: assert property (
		ce & hold_off |=> en_discharge & rail_on == 3'h0)
		else $error("hold-off left pins charging");
endmodule : trs_seq

// ===== tb/trs_far.sv
// far side of the sequencer: enable pins, soft-start pin, tick source
// assumes the sequencer drives pin sources and soft-start controls
`timescale 1ns/100ps
module trs_far
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [5:0]  pin_mode,
	input  wire logic [23:0] pin_dly,
	input  wire logic        en_source_on,
	input  wire logic        ss_precharge,
	input  wire logic        ss_charge,
	input  wire logic        ss_discharge,
	output logic [2:0]       rail_enable_input,
	output logic             ss_match,
	output logic             ss_done,
	output logic             sw_tick
);
	// ----------------------------------------------------------------
	// pin mode per rail: 0 grounded, 1 tied high, 2 ramp capacitor
	// ----------------------------------------------------------------
	logic [7:0] ramp [3];
	logic [3:0] pcnt;
	logic [3:0] ccnt;
	logic [2:0] tk;

	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			ramp <= '{default: 8'h00};
			pcnt <= 4'h0;
			ccnt <= 4'h0;
			tk   <= 3'h0;
		end
		else
		begin
			// capacitor only charges while the sources are on
			for (int i = 0; i < 3; i++)
				ramp[i] <= !en_source_on ? 8'h00 :
					ramp[i] + {7'h00, ramp[i] != 8'hff};
			pcnt <= ss_discharge ? 4'h0 :
				pcnt + {3'h0, ss_precharge && pcnt != 4'hf};
			ccnt <= ss_discharge ? 4'h0 :
				ccnt + {3'h0, ss_charge && ccnt != 4'hf};
			tk   <= tk + 3'h1;
		end

	always_comb
		for (int i = 0; i < 3; i++)
			rail_enable_input[i] = pin_mode[2*i+:2] == 2'h1 ||
				(pin_mode[2*i+:2] == 2'h2 && ramp[i] >= pin_dly[8*i+:8]);

	// slow pin: match after 3 cycles, 0.8 V after 8 of charging
	assign ss_match = pcnt >= 4'h3;
	assign ss_done  = ccnt >= 4'h8;
	assign sw_tick  = tk[2];
endmodule : trs_far

// ===== tb/trs_seq_tb.sv
// self-checking bench for the three-rail sequencer
// assumes trs_far stands in for pins and soft-start; ce high except for one 20-cycle freeze
`timescale 1ns/100ps
module trs_seq_tb
	import trs_pkg::*;
;
	localparam int SSM = 20;
	localparam int GAP = 10;
	localparam int HIC = 30;
	logic        clk = 1'h0;
	logic        reset_n = 1'h0;
	logic        ce = 1'h1;
	logic [3:0]  addr = 4'h0;
	logic        rd = 1'h0;
	logic        wr = 1'h0;
	logic [31:0] wdata = 32'h0;
	logic [5:0]  pin_mode = 6'h00;
	logic [23:0] pin_dly = 24'h0;
	logic        msl = 1'h0;
	logic        ssl = 1'h0;
	logic        hot = 1'h0;
	logic        cool = 1'h0;
	logic [2:0]  oc = 3'h0;
	logic [2:0]  uv = 3'h0;
	logic [31:0] rdata, q;
	logic [2:0]  pin_cmp, rail, hs;
	logic        waitreq, match, done, tick, dis, src, pre, chg, dch;
	int          err_count = 0;
	int          compares = 0;
	int          cyc = 0;
	int          t0;
	wire  [7:0]  w = {hs[0], dch, chg, pre, src, rail};

	always #2 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	trs_seq #(.P_SS_MIN(SSM), .P_GAP(GAP), .P_SS_DCH(5), .P_EN_DCH(5),
		.P_HICCUP(HIC)) uut (.clk(clk), .reset_n(reset_n), .ce(ce),
		.avs_address(addr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wdata), .avs_readdata(rdata),
		.avs_waitrequest(waitreq), .rail_enable_input(pin_cmp),
		.main_supply_low(msl), .secondary_supply_low(ssl),
		.thermal_hot(hot), .thermal_cooled(cool), .ss_match(match),
		.ss_done(done), .sw_tick(tick), .oc_detect(oc), .uv_detect(uv),
		.en_discharge(dis), .en_source_on(src), .rail_enable(rail),
		.hs_allow(hs), .ss_precharge(pre), .ss_charge(chg),
		.ss_discharge(dch));

	trs_far far (.clk(clk), .reset_n(reset_n), .pin_mode(pin_mode),
		.pin_dly(pin_dly), .en_source_on(src), .ss_precharge(pre),
		.ss_charge(chg), .ss_discharge(dch), .rail_enable_input(pin_cmp),
		.ss_match(match), .ss_done(done), .sw_tick(tick));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic wrap_up;
		$display("compares %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, exp, input string m);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic bus(input logic we, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= we;
		rd    <= !we;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (waitreq !== 1'h0 && n < 50);
		q = rdata;
		rd <= 1'h0;
		wr <= 1'h0;
		if (n >= 50)
		begin
			chk(32'h0, 32'h1, "bus timeout");
			wrap_up();
		end
	endtask : bus

	// bounded wait for one watched bit to reach a level
	task automatic wait_for(input int i, input logic v, input int lim);
		int n;
		n = 0;
		while (w[i] !== v && n < lim)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= lim)
		begin
			chk(32'h0, 32'h1, "wait timeout");
			wrap_up();
		end
	endtask : wait_for

	task automatic pw(input logic [5:0] m, input logic [23:0] d);
		reset_n  <= 1'h0;
		pin_mode <= m;
		pin_dly  <= d;
		repeat (16) @(posedge clk);
		chk(32'({dis, waitreq, rail}), 32'h18, "reset");
		reset_n  <= 1'h1;
	endtask : pw

	// ----------------------------------------------------------------
	// sequence of tests
	// ----------------------------------------------------------------
	initial
	begin
		pw(6'h00, 24'h0);
		repeat (2) @(posedge clk);
		chk(32'(dis), 32'h1, "pins discharged");
		wait_for(3, 1'h1, 20);
		bus(1'h0, REG_CTRL, 32'h0);
		chk(q, CTRL_RESET, "ctrl reset");
		bus(1'h1, 4'h8, 32'hffff_ffff);
		bus(1'h0, 4'h8, 32'h0);
		chk(q, 32'h0, "unmapped");
		bus(1'h1, REG_STATUS, 32'h1ff);
		bus(1'h0, REG_STATUS, 32'h0);
		chk(q, 32'h0, "status");
		repeat (100) @(posedge clk);
		chk(32'(rail), 32'h0, "grounded");
		bus(1'h1, REG_CTRL, 32'h1);
		bus(1'h0, REG_CTRL, 32'h0);
		chk(q, 32'h1, "ctrl");
		pin_mode <= 6'h15;
		repeat (100) @(posedge clk);
		chk(32'({dis, rail}), 32'h8, "hold off");
		bus(1'h1, REG_CTRL, 32'h0);
		$display("registers done");

		wait_for(0, 1'h1, 100);
		t0 = cyc;
		chk(32'(rail), 32'h1, "first");
		chk(32'({pre, chg}), 32'h2, "precharge");
		ce <= 1'h0;
		repeat (20) @(posedge clk);
		chk(32'({pre, chg, rail}), 32'h11, "frozen");
		ce <= 1'h1;
		bus(1'h0, REG_STATUS, 32'h0);
		chk(q, 32'h101, "status busy");
		wait_for(5, 1'h1, 100);
		wait_for(6, 1'h1, 200);
		chk(32'(rail), 32'h1, "ss discharge");
		wait_for(1, 1'h1, 200);
		chk(32'(cyc - t0 >= SSM + GAP), 32'h1, "gap");
		chk(32'(rail), 32'h3, "second");
		wait_for(2, 1'h1, 200);
		chk(32'(rail), 32'h7, "third");
		chk(32'(hs), 32'h7, "drive allowed");
		$display("default order done");

		msl <= 1'h1;
		repeat (6) @(posedge clk);
		chk(32'({dis, rail}), 32'h8, "main low");
		bus(1'h0, REG_STATUS, 32'h0);
		chk(32'(q[ST_LOCK]), 32'h1, "lock flag");
		msl <= 1'h0;
		wait_for(0, 1'h1, 100);
		wait_for(1, 1'h1, 300);
		ssl <= 1'h1;
		repeat (6) @(posedge clk);
		chk(32'({dis, rail}), 32'h8, "second low");
		ssl <= 1'h0;
		wait_for(0, 1'h1, 100);
		$display("lockout done");

		hot <= 1'h1;
		repeat (6) @(posedge clk);
		chk(32'({dis, rail}), 32'h8, "thermal");
		hot <= 1'h0;
		repeat (50) @(posedge clk);
		chk(32'(rail), 32'h0, "no early release");
		cool <= 1'h1;
		wait_for(0, 1'h1, 100);
		cool <= 1'h0;
		$display("thermal done");

		wait_for(7, 1'h1, 300);
		oc <= 3'h1;
		for (int k = 0; k < 6; k++)
		begin
			wait_for(7, 1'h0, 100);
			t0 = cyc;
			wait_for(7, 1'h1, 300);
			chk(32'((cyc - t0 + 4) / 8), 32'(k < 5 ? 1 << k : 16), "blank");
		end
		oc <= 3'h0;
		repeat (40) @(posedge clk);
		chk(32'(hs[0]), 32'h1, "blank cleared");
		$display("blanking done");

		oc <= 3'h1;
		uv <= 3'h1;
		wait_for(0, 1'h0, 60);
		t0 = cyc;
		bus(1'h0, REG_STATUS, 32'h0);
		chk(32'(q[ST_HIC_LSB +: 3]), 32'h1, "hiccup flag");
		wait_for(0, 1'h1, 400);
		chk(32'(cyc - t0 >= HIC), 32'h1, "hiccup off");
		wait_for(0, 1'h0, 200);
		oc <= 3'h0;
		uv <= 3'h0;
		wait_for(0, 1'h1, 400);
		repeat (100) @(posedge clk);
		chk(32'(rail[0]), 32'h1, "recovered");
		$display("hiccup done");

		pw(6'h1a, 24'h00_16_14);
		wait_for(2, 1'h1, 200);
		chk(32'(rail), 32'h4, "custom first");
		wait_for(0, 1'h1, 300);
		chk(32'(rail), 32'h5, "custom second");
		wait_for(1, 1'h1, 300);
		chk(32'(rail), 32'h7, "custom third");
		$display("custom order done");

		// delays spaced wider than soft-start plus gap
		pw(6'h2a, 24'h40_10_80);
		wait_for(1, 1'h1, 300);
		chk(32'(rail), 32'h2, "spaced first");
		wait_for(2, 1'h1, 300);
		chk(32'(rail), 32'h6, "spaced second");
		wait_for(0, 1'h1, 300);
		chk(32'(rail), 32'h7, "spaced third");
		$display("spaced order done");
		wrap_up();
	end
endmodule : trs_seq_tb
